// [core/serial_mem.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_mem_params.svh"

module serial_mem #(
    parameter int HALF_BITS   = `SMEM_HALF_BITS,
    parameter int FIFO_DEPTH  = `SMEM_FIFO_DEPTH,
    parameter int PHASE_CYCLES = `SMEM_PHASE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic chip_sel_one,
    input  wire logic chip_sel_two,
    input  wire logic store_en,
    input  wire logic out_en,
    input  wire logic serial_in,
    input  wire logic in_valid,
    output logic      in_ready,
    output logic      out_data,
    output logic      out_drive,
    output logic      out_valid,
    input  wire logic out_ready,
    output logic      phase_sel
);
    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic       rst_n;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    initial begin
        if (HALF_BITS < 2 || PHASE_CYCLES < 1 || PHASE_CYCLES > 65536) $error("geometry unsupported");
    end

    // ****************************************
    // input buffering
    // ****************************************
    // the fifo holds serial input bits; a phase waits while it is empty,
    // so the controller stalls the memory instead of losing bits
    logic fifo_bit;
    logic fifo_valid;
    logic fifo_pop;

    serial_mem_fifo #(
        .WIDTH (`SMEM_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_data   (serial_in),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .out_data  (fifo_bit),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [HALF_BITS-1:0]     loop_a;
        logic [HALF_BITS-1:0]     loop_b;
        logic                     phase;
        logic [15:0]              tick;
        serial_mem_pkg::out_pin_t pin;
        logic                     valid;
    } mem_state_t;

    mem_state_t          st_reg;
    mem_state_t          st_next;
    serial_mem_pkg::ctrl_t ctl;
    logic                phase_go;
    logic                sel;
    logic                tail;
    logic                head;

    assign ctl = '{chip_sel_one: chip_sel_one, chip_sel_two: chip_sel_two,
                   store_en: store_en, out_en: out_en, serial_in: fifo_bit};
    // a phase may only advance with an input bit and room at the output
    assign phase_go = (st_reg.tick == 16'(PHASE_CYCLES - 1)) && fifo_valid
                      && (!st_reg.valid || out_ready);
    assign fifo_pop = phase_go;
    assign sel      = ctl.chip_sel_one && ctl.chip_sel_two;
    assign tail     = st_reg.phase ? st_reg.loop_b[HALF_BITS-1]
                                   : st_reg.loop_a[HALF_BITS-1];
    assign head     = (sel && ctl.store_en) ? ctl.serial_in : tail;

    always_comb begin
        st_next = st_reg;
        if (out_ready) begin
            st_next.valid = 1'b0;
        end
        if (st_reg.tick != 16'(PHASE_CYCLES - 1)) begin
            st_next.tick = st_reg.tick + 16'h1;
        end
        if (phase_go) begin
            st_next.tick = 16'h0;
            // alternate loops each phase: two bits per clock period
            if (st_reg.phase) begin
                st_next.loop_b = {st_reg.loop_b[HALF_BITS-2:0], head};
            end else begin
                st_next.loop_a = {st_reg.loop_a[HALF_BITS-2:0], head};
            end
            st_next.phase     = ~st_reg.phase;
            // enables sampled now govern the following phase
            st_next.pin.drive = sel && ctl.out_en;
            st_next.pin.data  = sel && ctl.out_en && tail;
            st_next.valid     = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_data  = st_reg.pin.data;
    assign out_drive = st_reg.pin.drive;
    assign out_valid = st_reg.valid;
    assign phase_sel = st_reg.phase;
endmodule : serial_mem

`default_nettype wire

// [core/serial_mem_params.svh]
`ifndef SERIAL_MEM_PARAMS_SVH
`define SERIAL_MEM_PARAMS_SVH

// ****************************************
// geometry and timing
// ****************************************
`define SMEM_HALF_BITS     256
`define SMEM_FIFO_WIDTH    1
`define SMEM_FIFO_DEPTH    32
// one clock phase of the device, in ns
`define SMEM_PHASE_NS      200
`define SMEM_CLK_NS        10
`define SMEM_PHASE_CYCLES  ((`SMEM_PHASE_NS + `SMEM_CLK_NS - 1) / `SMEM_CLK_NS)

`endif

// [core/serial_mem_pkg.sv]
package serial_mem_pkg;

    // ****************************************
    // control inputs sampled before a phase
    // ****************************************
    typedef struct packed {
        logic chip_sel_one;
        logic chip_sel_two;
        logic store_en;
        logic out_en;
        logic serial_in;
    } ctrl_t;

    typedef struct packed {
        logic drive;
        logic data;
    } out_pin_t;

endpackage : serial_mem_pkg

// [core/serial_mem_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module serial_mem_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t st_reg;
    fifo_state_t st_next;
    logic        push;
    logic        pop;

    initial begin
        if (DEPTH < 2 || WIDTH < 1) $error("fifo geometry unsupported");
    end

    assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_reg.cnt != '0);
    assign out_data  = st_reg.mem[st_reg.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = (st_reg.wp == AW'(DEPTH-1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH-1)) ? '0 : st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule : serial_mem_fifo

`default_nettype wire

// [bench/serial_mem_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_mem_monitor (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic chip_sel_one,
    input wire logic chip_sel_two,
    input wire logic store_en,
    input wire logic out_en,
    input wire logic serial_in,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_data,
    input wire logic out_drive,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic phase_sel
);
    // ****************************************
    // output pin checks
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    chk_drive_sel: assert property (out_valid && out_drive |-> $past(chip_sel_one && chip_sel_two))
        else $error("output driven while unselected");
    chk_drive_read: assert property (out_valid && out_drive |-> $past(out_en))
        else $error("output driven without read enable");
    chk_quiet_low: assert property (!out_drive |-> !out_data)
        else $error("undriven output not low");
    chk_drive_next: assert property ($rose(out_valid) && $past(out_en && chip_sel_one && chip_sel_two) |-> out_drive)
        else $error("enabled output not driven next phase");
    chk_drive_step: assert property ($changed(out_drive) |-> out_valid)
        else $error("drive changed outside a phase");
    chk_phase_step: assert property ($changed(phase_sel) |-> out_valid)
        else $error("loop switched without a phase");
    chk_valid_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output lost while stalled");
    cover property ($rose(out_drive));
    cover property (out_valid && !out_ready);
    cover property ($changed(phase_sel));
endmodule : serial_mem_monitor
`default_nettype wire

// [bench/out_consumer.sv]
`timescale 1ns/1ps
`default_nettype none
module out_consumer (
    input wire logic clk,
    input wire logic rst_n,
    output logic     ready
);
    // stalls one cycle in four, so held output gets exercised
    logic [1:0] cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cnt_reg <= 2'h0;
        else cnt_reg <= cnt_reg + 2'h1;
    end
    assign ready = cnt_reg != 2'h3;
endmodule : out_consumer
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // stimulus and checks
    // ****************************************
    logic                  sys_clk, nrst, in_valid, in_ready, out_data, out_drive, out_valid, out_ready, phase_sel;
    serial_mem_pkg::ctrl_t ctl;
    int                    mismatches, samples_checked;
    logic [7:0]            pat;
    logic [1:0]            got;
    serial_mem #(.HALF_BITS(4), .PHASE_CYCLES(1)) dut_u (.sys_clk(sys_clk), .nrst(nrst),
        .chip_sel_one(ctl.chip_sel_one), .chip_sel_two(ctl.chip_sel_two), .store_en(ctl.store_en),
        .out_en(ctl.out_en), .serial_in(ctl.serial_in), .in_valid(in_valid), .in_ready(in_ready),
        .out_data(out_data), .out_drive(out_drive), .out_valid(out_valid), .out_ready(out_ready),
        .phase_sel(phase_sel));
    out_consumer far_u (.clk(sys_clk), .rst_n(nrst), .ready(out_ready));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task test_done();
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task check(input logic [1:0] seen, input logic [1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one bit per phase; controls held until the phase has taken them
    task op(input serial_mem_pkg::ctrl_t c);
        @(posedge sys_clk);
        check({1'b0, in_ready}, 2'b01);
        ctl <= c;
        in_valid <= 1'b1;
        @(posedge sys_clk);
        in_valid <= 1'b0;
        got = 2'bxx;
        for (int n = 0; n < 40; n++) begin
            @(negedge sys_clk);
            if (out_valid === 1'b1 && out_ready === 1'b1) begin
                got = {out_drive, out_data};
                break;
            end
        end
    endtask : op
    task t_fill();
        for (int i = 0; i < 8; i++) begin
            op('{1'b1, 1'b1, 1'b1, 1'b1, pat[i]});
            check(got, 2'b10);
        end
    endtask : t_fill
    task t_recirc();
        for (int i = 0; i < 8; i++) begin
            op('{1'b1, 1'b1, 1'b0, 1'b1, ~pat[i]});
            check(got, {1'b1, pat[i]});
        end
    endtask : t_recirc
    task t_desel();
        for (int i = 0; i < 8; i++) begin
            op('{i % 3 != 0, i % 3 != 1, i % 3 != 2, i % 3 != 2, ~pat[i]});
            check(got, 2'b00);
        end
    endtask : t_desel
    initial begin
        nrst = 1'b0;
        in_valid = 1'b0;
        ctl = '0;
        mismatches = 0;
        samples_checked = 0;
        pat = 8'hb4;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_fill();
        t_recirc();
        t_desel();
        t_recirc();
        test_done();
    end
    initial begin
        #20000;
        mismatches++;
        test_done();
    end
endmodule : testbench
bind serial_mem serial_mem_monitor mon_u (.sys_clk(sys_clk), .nrst(nrst), .chip_sel_one(chip_sel_one),
    .chip_sel_two(chip_sel_two), .store_en(store_en), .out_en(out_en), .serial_in(serial_in),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data), .out_drive(out_drive),
    .out_valid(out_valid), .out_ready(out_ready), .phase_sel(phase_sel));
`default_nettype wire
